// [serial_port_consts.svh]
// Register offsets, field positions, reset values and counts of the serial port.
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH
// ==========================================================================
// Register byte offsets
`define ADDR_CSR 4'h0
`define ADDR_CTRL 4'h4
`define ADDR_TXD 4'h8
`define ADDR_RXD 4'hc
// ==========================================================================
// Control and status register fields
`define CSR_MODE_HI 31
`define CSR_MODE_LO 30
`define CSR_PCE 29
`define CSR_SLEEPLESS 27
`define CSR_CLR_UNDER 21
`define CSR_CLR_OVER 20
`define CSR_CLR_FRAME 19
`define CSR_CLR_PIN 18
`define CSR_FREE_HI 15
`define CSR_FREE_LO 12
`define CSR_HELD_HI 11
`define CSR_HELD_LO 8
`define CSR_RESET 32'h0000f000
// ==========================================================================
// Port control register fields
`define CTRL_THR_HI 3
`define CTRL_THR_LO 0
`define CTRL_TX_EN 8
`define CTRL_RX_EN 9
`define CTRL_TIE 10
`define CTRL_RIE 11
`define CTRL_THR_RST 4'h1
// ==========================================================================
// Serial word
`define HALF_BITS_LEFT 4'hf
`define HELD_MAX 4'hf
`endif

// [serial_port_pkg.sv]
// Types shared by the serial port files.
package serial_port_pkg;
   typedef logic [31:0] word_t;
   typedef logic [15:0] half_t;
   typedef enum logic [1:0] {mode_normal0, mode_normal1, mode_remote,
      mode_local} test_mode_t;
endpackage

// [pin_sync.sv]
// Two-stage synchroniser for a group of asynchronous inputs.
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 6
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   // ==========================================================================
   // The first stage feeds only the second stage.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// [serial_port_status_control.sv]
// Control, status, queues and serial word engine of the serial port.
`timescale 1ns/10ps
`include "serial_port_consts.svh"
module serial_port_status_control #(
   parameter int TX_DEPTH = 15,
   parameter int RX_DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic receive_bit_clock_pin,
   input wire logic rx_data_pin,
   input wire logic frame_sync_pin,
   input wire logic gp_pin_a,
   input wire logic gp_pin_b,
   input wire logic power_down_req,
   output logic tx_data_pin,
   output logic irq
);
   // ==========================================================================
   // Synchronised pins and bit clock edges
   logic [5:0] s;
   logic rck_prev;
   logic gpa_prev;
   pin_sync #(.WIDTH(6)) u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .async_in({power_down_req, gp_pin_b, gp_pin_a, frame_sync_pin,
         rx_data_pin, receive_bit_clock_pin}),
      .sync_out(s)
   );
   wire rise = s[0] & ~rck_prev;
   wire sync_seen = s[2];
   wire pd_in = s[5];

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rck_prev <= 1'b0;
         gpa_prev <= 1'b0;
      end else begin
         rck_prev <= s[0];
         gpa_prev <= s[3];
      end
   end
   function automatic logic [3:0] bump(input logic [3:0] p, input int depth);
      return (p == 4'(depth - 1)) ? 4'h0 : p + 4'h1;
   endfunction

   // ==========================================================================
   // Software visible state
   serial_port_pkg::test_mode_t tmode;
   logic pce, sleepless, tx_en, rx_en, tx_irq_enable, rx_irq_enable;
   logic [3:0] thr;
   logic underrun_flag, over_flag, tx_frm, rx_frm, pin_change_flag;
   logic tx_service_flag, rx_service_flag;

   wire sel_csr = reg_addr == `ADDR_CSR;
   wire sel_ctrl = reg_addr == `ADDR_CTRL;
   wire sel_txd = reg_addr == `ADDR_TXD;
   wire sel_rxd = reg_addr == `ADDR_RXD;
   wire wr_csr = reg_wr & sel_csr;
   wire wr_ctrl = reg_wr & sel_ctrl;
   wire clr_under = wr_csr & reg_wdata[`CSR_CLR_UNDER];
   wire clr_over = wr_csr & reg_wdata[`CSR_CLR_OVER];
   wire clr_frame = wr_csr & reg_wdata[`CSR_CLR_FRAME];
   wire clr_pin = wr_csr & reg_wdata[`CSR_CLR_PIN];

   wire remote = tmode == serial_port_pkg::mode_remote;
   wire local_lb = tmode == serial_port_pkg::mode_local;
   wire pd_stop = pd_in & ~sleepless;
   // remote mode stops the data path
   wire tx_run = tx_en & ~pd_stop & ~remote;
   wire rx_run = rx_en & ~pd_stop & ~remote;

   // ==========================================================================
   // Transmit queue
   serial_port_pkg::word_t tx_mem [TX_DEPTH];
   logic [3:0] tx_wp, tx_rp, tx_cnt;
   wire tx_full = tx_cnt == 4'(TX_DEPTH);
   wire tx_empty = tx_cnt == 4'h0;
   // writes to a full queue are dropped
   wire tx_push = reg_wr & sel_txd & ~tx_full;
   wire [3:0] tx_free = 4'(TX_DEPTH) - tx_cnt;

   // ==========================================================================
   // Transmit serialiser
   serial_port_pkg::half_t tx_shift, tx_hold;
   logic [3:0] tx_left;
   logic tx_half;
   wire tx_start = rise & sync_seen & tx_run & (tx_left == 4'h0);
   // load due with an empty queue
   wire set_under = tx_start & ~tx_half & tx_empty;
   wire tx_pop = tx_start & ~tx_half & ~tx_empty;
   wire [31:0] tx_head = tx_mem[tx_rp];
   wire [15:0] tx_load = tx_half ? tx_hold :
      (tx_empty ? 16'h0000 : tx_head[31:16]);
   wire tx_bit = tx_start ? tx_load[15] : tx_shift[15];
   wire tx_shifting = rise & (tx_left != 4'h0);
   wire set_tx_frm = rise & sync_seen & (tx_left != 4'h0) & ~remote;
   wire [3:0] next_tx_cnt = tx_cnt + 4'(tx_push) - 4'(tx_pop);

   always_ff @(posedge ref_clk) begin
      if (tx_push) begin
         tx_mem[tx_wp] <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         tx_wp <= 4'h0;
         tx_rp <= 4'h0;
         tx_cnt <= 4'h0;
      end else begin
         tx_wp <= tx_push ? bump(tx_wp, TX_DEPTH) : tx_wp;
         tx_rp <= tx_pop ? bump(tx_rp, TX_DEPTH) : tx_rp;
         tx_cnt <= next_tx_cnt;
      end
   end

   // a started half always runs to its end
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         tx_shift <= 16'h0000;
         tx_hold <= 16'h0000;
         tx_left <= 4'h0;
         tx_half <= 1'b0;
      end else if (tx_start) begin
         tx_shift <= {tx_load[14:0], 1'b0};
         tx_left <= `HALF_BITS_LEFT;
         tx_hold <= tx_half ? tx_hold : tx_head[15:0];
         tx_half <= ~tx_half & ~tx_empty;
      end else if (tx_shifting) begin
         tx_shift <= {tx_shift[14:0], 1'b0};
         tx_left <= tx_left - 4'h1;
         tx_half <= tx_half & ~(pd_stop & (tx_left == 4'h1));
      end
   end

   // remote mode echoes the line, clocked by the bit clock
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         tx_data_pin <= 1'b0;
      end else if (rise & remote) begin
         tx_data_pin <= s[1];
      end else if (tx_start | tx_shifting) begin
         tx_data_pin <= tx_bit;
      end
   end

   // ==========================================================================
   // Receive deserialiser and queue
   serial_port_pkg::word_t rx_mem [RX_DEPTH];
   serial_port_pkg::half_t rx_sh, rx_hi;
   logic [3:0] rx_left, rx_wp, rx_rp;
   logic [4:0] rx_cnt;
   logic rx_half;
   // local loopback takes the serialiser output
   wire rx_bit = local_lb ? tx_bit : s[1];
   wire rx_start = rise & sync_seen & rx_run & (rx_left == 4'h0);
   wire rx_shifting = rise & (rx_left != 4'h0);
   wire rx_done = rx_shifting & (rx_left == 4'h1);
   wire [15:0] rx_word = {rx_sh[14:0], rx_bit};
   wire set_rx_frm = rise & sync_seen & (rx_left != 4'h0) & ~remote;
   wire rx_full = rx_cnt == 5'(RX_DEPTH);
   wire rx_empty = rx_cnt == 5'h00;
   // a stopping receiver stores its last half at once
   wire rx_store = rx_done & (rx_half | pd_stop);
   wire [31:0] rx_data = rx_half ? {rx_hi, rx_word} : {rx_word, 16'h0000};
   // no free slot loses the word
   wire set_over = rx_store & rx_full;
   wire rx_push = rx_store & ~rx_full;
   wire rx_pop = reg_rd & sel_rxd & ~rx_empty;
   wire [3:0] rx_held = rx_full ? `HELD_MAX : rx_cnt[3:0];
   wire [4:0] next_rx_cnt = rx_cnt + 5'(rx_push) - 5'(rx_pop);

   always_ff @(posedge ref_clk) begin
      if (rx_push) begin
         rx_mem[rx_wp] <= rx_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rx_sh <= 16'h0000;
         rx_hi <= 16'h0000;
         rx_left <= 4'h0;
         rx_half <= 1'b0;
      end else if (rx_start) begin
         rx_sh <= {15'h0000, rx_bit};
         rx_left <= `HALF_BITS_LEFT;
      end else if (rx_shifting) begin
         rx_sh <= rx_word;
         rx_left <= rx_left - 4'h1;
         rx_hi <= (rx_done & ~rx_half) ? rx_word : rx_hi;
         rx_half <= rx_done ? (~rx_half & ~pd_stop) : rx_half;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rx_wp <= 4'h0;
         rx_rp <= 4'h0;
         rx_cnt <= 5'h00;
      end else begin
         rx_wp <= rx_push ? bump(rx_wp, RX_DEPTH) : rx_wp;
         rx_rp <= rx_pop ? bump(rx_rp, RX_DEPTH) : rx_rp;
         rx_cnt <= next_rx_cnt;
      end
   end

   // ==========================================================================
   // Control registers
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         tmode <= serial_port_pkg::mode_normal0;
         pce <= 1'b0;
         sleepless <= 1'b0;
      end else if (wr_csr) begin
         tmode <= serial_port_pkg::test_mode_t'(
            reg_wdata[`CSR_MODE_HI:`CSR_MODE_LO]);
         pce <= reg_wdata[`CSR_PCE];
         sleepless <= reg_wdata[`CSR_SLEEPLESS];
      end
   end

   // a zero threshold is raised to one
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         thr <= `CTRL_THR_RST;
         {tx_en, rx_en, tx_irq_enable, rx_irq_enable} <= 4'h0;
      end else if (wr_ctrl) begin
         thr <= (reg_wdata[3:0] == 4'h0) ? 4'h1 : reg_wdata[3:0];
         tx_en <= reg_wdata[`CTRL_TX_EN];
         rx_en <= reg_wdata[`CTRL_RX_EN];
         tx_irq_enable <= reg_wdata[`CTRL_TIE];
         rx_irq_enable <= reg_wdata[`CTRL_RIE];
      end
   end

   // ==========================================================================
   // Status flags
   // any change of the sampled pin
   wire set_pin = s[3] ^ gpa_prev;
   // hysteresis between above and below the threshold
   wire next_tx_service = (tx_free > thr) ? 1'b1 :
      ((tx_free < thr) ? 1'b0 : tx_service_flag);

   // sticky flags, set wins over clear; the receive service flag follows its level each cycle, the transmit one its hysteresis
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         underrun_flag <= 1'b0;
         over_flag <= 1'b0;
         tx_frm <= 1'b0;
         rx_frm <= 1'b0;
         pin_change_flag <= 1'b0;
         tx_service_flag <= 1'b0;
         rx_service_flag <= 1'b0;
      end else begin
         underrun_flag <= (underrun_flag & ~clr_under) | set_under;
         over_flag <= (over_flag & ~clr_over) | set_over;
         // either side raises the shared framing flag
         tx_frm <= (tx_frm & ~clr_frame) | set_tx_frm;
         rx_frm <= (rx_frm & ~clr_frame) | set_rx_frm;
         pin_change_flag <= (pin_change_flag & ~clr_pin) | set_pin;
         tx_service_flag <= next_tx_service;
         rx_service_flag <= rx_held > thr;
      end
   end

   // ==========================================================================
   // Interrupt request and read data
   // pin change interrupts only when enabled
   wire next_irq = ~remote & (
      (tx_irq_enable & (tx_service_flag | underrun_flag | tx_frm)) |
      (rx_irq_enable & (rx_service_flag | over_flag | rx_frm)) |
      (pce & pin_change_flag));
   // first pin level; second pin level at bit 0
   wire [31:0] csr_view = {tmode, pce, 1'b0, sleepless, 5'h00, 4'h0, 2'h0,
      tx_free, rx_held, tx_service_flag, rx_service_flag, underrun_flag,
      over_flag, tx_frm | rx_frm, pin_change_flag, s[3], s[4]};
   wire [31:0] ctrl_view = {20'h00000, rx_irq_enable, tx_irq_enable, rx_en, tx_en, 4'h0, thr};
   wire [31:0] rd_mux = sel_csr ? csr_view : sel_ctrl ? ctrl_view :
      (sel_rxd & ~rx_empty) ? rx_mem[rx_rp] : 32'h00000000;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         reg_rdata <= 32'h00000000;
         irq <= 1'b0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
         irq <= next_irq;
      end
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_action_bits_zero: assert property (
      reg_rd && sel_csr |=> reg_rdata[21:18] == 4'h0)
      else $error("action bits read nonzero");
   a_full_write_drop: assert property (
      reg_wr && sel_txd && tx_full |=> $stable(tx_wp))
      else $error("write to full queue taken");
   a_free_slot_view: assert property (
      reg_rd && sel_csr |=> reg_rdata[15:12] == 4'hf - $past(tx_cnt))
      else $error("free slot count wrong");
   a_held_saturate: assert property (
      reg_rd && sel_csr && rx_full |=> reg_rdata[11:8] == 4'hf)
      else $error("held count not saturated");
   a_underrun_set: assert property (
      set_under |=> underrun_flag [*2] or (underrun_flag ##1 1'b1))
      else $error("underrun not flagged");
   a_overrun_set: assert property (
      rx_store && rx_full |=> over_flag && $stable(rx_wp))
      else $error("overrun not flagged");
   a_flag_sticky: assert property (
      over_flag && !clr_over |=> over_flag)
      else $error("overrun flag dropped");
   a_clear_wins_alone: assert property (
      clr_over && !set_over |=> !over_flag)
      else $error("overrun not cleared");
   a_remote_echo: assert property (
      rise && remote |=> tx_data_pin == $past(s[1]) && !irq)
      else $error("remote echo wrong");
   a_sleepless_run: assert property (
      rise && sync_seen && tx_en && sleepless && !remote && tx_left == 4'h0
      |=> tx_left == 4'hf)
      else $error("sleepless port did not start");
   a_pin_change: assert property (
      s[3] != gpa_prev |=> pin_change_flag)
      else $error("pin change missed");
   a_thr_range: assert property (
      thr != 4'h0)
      else $error("threshold zero");
endmodule

// [serial_link_partner.sv]
// Behavioural external serial device that faces the link pins of the port.
`timescale 1ns/10ps
module serial_link_partner (
   output logic bit_clk,
   output logic sync,
   output logic rx_data,
   input wire logic tx_data
);
   initial begin
      bit_clk = 1'b0;
      sync = 1'b0;
      rx_data = 1'b1;
   end
   // ========================================
   // Frame transfer
   // clock in loopback: the clock runs in every frame, whatever the mode.
   // The clock stands low between frames; edges come only inside words.
   task automatic frame(input serial_port_pkg::half_t din, input logic mid,
         output serial_port_pkg::half_t dout);
      for (int i = 15; i >= 0; i--) begin
         #100;
         if (i < 15) begin
            dout[i + 1] = tx_data;
         end
         // Sync is one bit long; a second pulse inside the word is an error.
         sync = (i == 15) || (mid && i == 7);
         rx_data = din[i];
         #100 bit_clk = 1'b1;
         #200 bit_clk = 1'b0;
      end
      #100 dout[0] = tx_data;
      sync = 1'b0;
      // A released line shows the inverse, so a stale bit can never match.
      rx_data = ~rx_data;
   endtask
endmodule

// [serial_port_status_control_tb.sv]
// Self-checking bench for the serial port control and status block.
`timescale 1ns/10ps
`include "serial_port_consts.svh"
module serial_port_status_control_tb;
   logic ref_clk, rst_b, reg_wr, reg_rd, gp_pin_a, gp_pin_b, power_down_req;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic bit_clk, sync, rx_data, tx_data_pin, irq;
   logic rd_seen = 1'b0;
   serial_port_pkg::word_t eq[$], mq[$], txq[$], rxq[$];
   serial_port_pkg::word_t w, r, got;
   int n_mismatch = 0;
   int samples_checked = 0;
   int fr;
   serial_port_status_control DUT (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .receive_bit_clock_pin(bit_clk),
      .rx_data_pin(rx_data),
      .frame_sync_pin(sync),
      .gp_pin_a(gp_pin_a),
      .gp_pin_b(gp_pin_b),
      .power_down_req(power_down_req),
      .tx_data_pin(tx_data_pin),
      .irq(irq)
   );
   serial_link_partner link_dev (
      .bit_clk(bit_clk),
      .sync(sync),
      .rx_data(rx_data),
      .tx_data(tx_data_pin)
   );
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // ========================================
   // Bus tasks and checks
   task automatic fail(input string s);
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, s);
   endtask
   task automatic end_of_test();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input serial_port_pkg::word_t d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // The expected word and its mask wait in the queue until the data stand.
   task automatic rd(input logic [3:0] a, input serial_port_pkg::word_t e, m);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      eq.push_back(e);
      mq.push_back(m);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask
   task automatic chk(input serial_port_pkg::word_t g, e);
      samples_checked++;
      if (g !== e) begin
         fail($sformatf("got %h expected %h", g, e));
      end
   endtask
   // The interrupt is registered from registered flags, so allow it to settle.
   task automatic chk_irq(input logic e);
      repeat (3) @(posedge ref_clk);
      #1;
      samples_checked++;
      if (irq !== e) begin
         fail("interrupt level wrong");
      end
   endtask
   task automatic xfer(input serial_port_pkg::word_t d, input logic mid,
         output serial_port_pkg::word_t t);
      serial_port_pkg::half_t hi, lo;
      link_dev.frame(d[31:16], mid, hi);
      link_dev.frame(d[15:0], 1'b0, lo);
      t = {hi, lo};
      repeat (10) @(posedge ref_clk);
   endtask
   // ========================================
   // Scoreboard of register reads
   always @(posedge ref_clk) begin
      if (rd_seen === 1'b1) begin
         samples_checked++;
         if ((reg_rdata & mq[0]) !== (eq[0] & mq[0])) begin
            fail($sformatf("read %h expected %h", reg_rdata, eq[0]));
         end
         eq.delete(0);
         mq.delete(0);
      end
      rd_seen <= reg_rd;
   end
   initial begin
      #3000000;
      fail("watchdog expired");
      end_of_test();
   end
   // ========================================
   // Tests
   initial begin
      rst_b <= 1'b0;
      reg_addr <= 4'h0;
      reg_wdata <= 32'h0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      gp_pin_a <= 1'b0;
      gp_pin_b <= 1'b0;
      power_down_req <= 1'b0;
      void'($urandom(32'h5157288c));
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rd(`ADDR_CSR, 32'h0000f080, '1);
      rd(`ADDR_CTRL, 32'h1, '1);
      rd(4'h2, 32'h0, '1);
      wr(4'h2, '1);
      wr(`ADDR_CTRL, 32'h0);
      rd(`ADDR_CTRL, 32'h1, '1);
      wr(`ADDR_CTRL, 32'h4);
      for (int n = 0; n < 16; n++) begin
         fr = (n < 15) ? 15 - n : 0;
         w = {16'h0, fr[3:0], 4'h0, fr >= 4, 7'h0};
         rd(`ADDR_CSR, w, 32'hf080);
         w = $urandom;
         wr(`ADDR_TXD, w);
         if (n < 15) txq.push_back(w);
      end
      rd(`ADDR_CSR, 32'h0, 32'hf000);
      wr(`ADDR_CSR, 32'h40000000);
      wr(`ADDR_CTRL, 32'h304);
      for (int k = 0; k < 17; k++) begin
         r = $urandom;
         xfer(r, 1'b0, got);
         if (k < 16) rxq.push_back(r);
         chk(got, (k < 15) ? txq[k] : 32'h0);
         if (k == 15) rd(`ADDR_CSR, 32'h0000ffe0, 32'hfff8);
      end
      wr(`ADDR_CTRL, 32'hb04);
      rd(`ADDR_CSR, 32'h0000fff0, 32'hfff8);
      for (int j = 0; j < 16; j++) rd(`ADDR_RXD, rxq[j], '1);
      rd(`ADDR_RXD, 32'h0, '1);
      rd(`ADDR_CSR, 32'h30, 32'hf70);
      chk_irq(1'b1);
      wr(`ADDR_CSR, 32'h40100000);
      rd(`ADDR_CSR, 32'h20, 32'h003c0030);
      chk_irq(1'b0);
      wr(`ADDR_CSR, 32'h40200000);
      rd(`ADDR_CSR, 32'h0, 32'h003c0030);
      r = $urandom;
      xfer(r, 1'b1, got);
      rd(`ADDR_CSR, 32'h8, 32'h8);
      rd(`ADDR_CSR, 32'h8, 32'h8);
      wr(`ADDR_CSR, 32'h40080000);
      rd(`ADDR_CSR, 32'h0, 32'h003c0008);
      rd(`ADDR_RXD, r, '1);
      w = $urandom;
      wr(`ADDR_TXD, w);
      @(posedge ref_clk) power_down_req <= 1'b1;
      xfer($urandom, 1'b0, got);
      rd(`ADDR_CSR, 32'h0000e000, 32'hff00);
      wr(`ADDR_CSR, 32'h48000000);
      r = $urandom;
      xfer(r, 1'b0, got);
      chk(got, w);
      rd(`ADDR_RXD, r, '1);
      wr(`ADDR_CSR, 32'h40000000);
      @(posedge ref_clk) power_down_req <= 1'b0;
      w = $urandom;
      wr(`ADDR_TXD, w);
      r = $urandom;
      fork
         xfer(r, 1'b0, got);
         begin
            repeat (100) @(posedge ref_clk);
            power_down_req <= 1'b1;
         end
      join
      chk(got[31:16], w[31:16]);
      rd(`ADDR_RXD, {r[31:16], 16'h0}, '1);
      @(posedge ref_clk) power_down_req <= 1'b0;
      @(posedge ref_clk) gp_pin_a <= 1'b1;
      repeat (5) @(posedge ref_clk);
      rd(`ADDR_CSR, 32'h6, 32'h7);
      @(posedge ref_clk) gp_pin_b <= 1'b1;
      repeat (5) @(posedge ref_clk);
      rd(`ADDR_CSR, 32'h7, 32'h7);
      chk_irq(1'b0);
      wr(`ADDR_CSR, 32'h60000000);
      chk_irq(1'b1);
      wr(`ADDR_CSR, 32'h60040000);
      rd(`ADDR_CSR, 32'h20000003, 32'h203c0007);
      chk_irq(1'b0);
      wr(`ADDR_CTRL, 32'h4);
      wr(`ADDR_CSR, 32'h80000000);
      wr(`ADDR_CTRL, 32'hf04);
      r = $urandom;
      xfer(r, 1'b0, got);
      chk(got, r);
      rd(`ADDR_CSR, 32'h0, 32'h0f10);
      chk_irq(1'b0);
      wr(`ADDR_CTRL, 32'h4);
      wr(`ADDR_CSR, 32'hc0000000);
      wr(`ADDR_CTRL, 32'h304);
      w = $urandom;
      wr(`ADDR_TXD, w);
      xfer($urandom, 1'b0, got);
      rd(`ADDR_RXD, w, '1);
      repeat (3) @(posedge ref_clk);
      end_of_test();
   end
endmodule
